// ### design/ppfs_pkg.sv
// Constants and types for the port pin function select block.
// Assumes a single clock domain and a plain strobe register port.
// ==========================================================
package ppfs_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] ADDR_DATA    = 4'h0; // port_data_register
   localparam logic [3:0] ADDR_DIR     = 4'h1; // direction_select
   localparam logic [3:0] ADDR_OTYPE   = 4'h2; // output_type_select
   localparam logic [3:0] ADDR_ANALOG  = 4'h3; // analog_digital_select
   localparam logic [3:0] ADDR_OSC     = 4'h4; // oscillator_pin_mode_register
   localparam logic [3:0] ADDR_PIN     = 4'h5; // raw pin levels, read only
   localparam logic [3:0] ADDR_BITSET  = 4'h6; // single-bit manipulation
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_DATA     = 8'h00;
   localparam logic [7:0] RST_DIR      = 8'hff; // all inputs
   localparam logic [7:0] RST_OTYPE    = 8'h00;
   localparam logic [7:0] RST_ANALOG   = 8'h00;
   localparam logic [7:0] RST_OSC      = 8'h00;
   // ==========================================================
   // Oscillator field positions and codes
   localparam int         OSC_EXT_BIT  = 7; // external_clock_select
   localparam int         OSC_SEL_BIT  = 6; // oscillator_select
   localparam logic [1:0] OSC_RESON    = 2'h1;
   localparam logic [1:0] OSC_EXTCLK   = 2'h3;
   // Bit-operation write data layout: bit index and value
   localparam int         BOP_IDX_LSB  = 0;
   localparam int         BOP_VAL_BIT  = 3;
   localparam int         BOP_OP_BIT   = 4; // 1 set/clear, 0 toggle
   // Read-modify-write sequencer states
   typedef enum logic [1:0] {BopIdle, BopRead, BopWrite} ppfs_bop_t;
endpackage

// ### design/ppfs_port.sv
// One 8-bit port with direction, output type, analog select and the
// two oscillator pin modes. Assumes synchronous pin inputs.
`timescale 1ns/1ps
module ppfs_port
   import ppfs_pkg::*;
#(
   parameter int         WIDTH       = 8,
   parameter logic [7:0] ANALOG_ONLY = 8'h00, // pins analog-only in pkg
   parameter bit         SMALL_PKG   = 1'b0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Register port
   input  wire logic [3:0]       regAddr,
   input  wire logic [7:0]       regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic      [7:0]       regRdata,
   // Alternate function outputs
   input  wire logic [WIDTH-1:0] serialOut,  // serial_array_unit, idle 1
   input  wire logic [WIDTH-1:0] otherOut,   // timers etc, idle 0
   // Pins
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinOut,
   output logic      [WIDTH-1:0] pinOe,
   output logic      [WIDTH-1:0] pinAnalog,  // analog switch enable
   // Oscillator pins
   output logic      [1:0]       oscPinMode, // external/oscillator select
   output logic                  oscResonEn,
   output logic                  oscExtClkEn,
   output logic                  busy        // bit operation running
);
   // ==========================================================
   // State
   logic [7:0] dataR, dataNxt;     // Output latches
   logic [7:0] dirR, dirNxt;       // direction_select
   logic [7:0] otypeR, otypeNxt;   // output_type_select
   logic [7:0] anaR, anaNxt;       // analog_digital_select
   logic [7:0] oscR, oscNxt;       // oscillator_pin_mode_register
   logic [7:0] rdR, rdNxt;         // Read data register
   logic [4:0] bopR, bopNxt;       // Pending bit operation
   logic [7:0] bufR, bufNxt;       // RMW read buffer
   ppfs_bop_t  stR, stNxt;
   logic [7:0] effAna;             // Analog select incl. package forcing
   logic [7:0] dataView;           // Latch for outputs, pin for inputs

   // Analog forcing in the small package
   assign effAna = anaR | (SMALL_PKG ? ANALOG_ONLY : 8'h00);

   // Read view of the data register
   // Output pins read back their latch, input pins their level
   function automatic logic [7:0] data_view(input logic [7:0] dir,
      input logic [7:0] lat, input logic [7:0] pins);
      data_view = (dir & pins) | (~dir & lat);
   endfunction
   assign dataView = data_view(dirR, dataR, 8'(pinIn));

   // ==========================================================
   // Next state: register writes and bit sequencer
   always_comb begin
      dataNxt  = dataR;
      dirNxt   = dirR;
      otypeNxt = otypeR;
      anaNxt   = anaR;
      oscNxt   = oscR;
      bopNxt   = bopR;
      bufNxt   = bufR;
      stNxt    = stR;
      rdNxt    = 8'h00;
      case (stR)
         BopIdle: begin
            if (regWr) begin
               case (regAddr)
                  // Writes to input pins land only in the latch
                  ADDR_DATA:   dataNxt  = regWdata;
                  ADDR_DIR:    dirNxt   = regWdata;
                  ADDR_OTYPE:  otypeNxt = regWdata;
                  ADDR_ANALOG: anaNxt   = regWdata;
                  ADDR_OSC:    oscNxt   = regWdata;
                  ADDR_BITSET: begin
                     bopNxt = regWdata[4:0];
                     stNxt  = BopRead;
                  end
                  default: ;
               endcase
            end
         end
         BopRead: begin
            // Whole byte read: input pins give pin level
            bufNxt = dataView;
            stNxt  = BopWrite;
         end
         BopWrite: begin
            // Modify one bit then write all eight back
            // Register writes arriving now are dropped silently
            dataNxt = bufR;
            if (bopR[BOP_OP_BIT])
               dataNxt[bopR[BOP_IDX_LSB +: 3]] = bopR[BOP_VAL_BIT];
            else
               dataNxt[bopR[BOP_IDX_LSB +: 3]] =
                  ~bufR[bopR[BOP_IDX_LSB +: 3]];
            stNxt = BopIdle;
         end
         default: stNxt = BopIdle;
      endcase
      if (regRd) begin
         case (regAddr)
            ADDR_DATA:   rdNxt = dataView;
            ADDR_DIR:    rdNxt = dirR;
            ADDR_OTYPE:  rdNxt = otypeR;
            ADDR_ANALOG: rdNxt = effAna;
            ADDR_OSC:    rdNxt = oscR;
            ADDR_PIN:    rdNxt = 8'(pinIn);
            default:     rdNxt = 8'h00;
         endcase
      end
   end

   // Reset branch loads constants only
   // Register stage; reset puts every pin in input mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataR  <= RST_DATA;
         dirR   <= RST_DIR;
         otypeR <= RST_OTYPE;
         anaR   <= RST_ANALOG;
         oscR   <= RST_OSC;
         rdR    <= 8'h00;
         bopR   <= 5'h00;
         bufR   <= 8'h00;
         stR    <= BopIdle;
      end else begin
         dataR  <= dataNxt;
         dirR   <= dirNxt;
         otypeR <= otypeNxt;
         anaR   <= anaNxt;
         oscR   <= oscNxt;
         rdR    <= rdNxt;
         bopR   <= bopNxt;
         bufR   <= bufNxt;
         stR    <= stNxt;
      end
   end

   // Read data stand one cycle; zero when no read was made
   assign regRdata = rdR;
   // Software polls busy; writes are refused while it is high
   assign busy     = (stR != BopIdle);

   // ==========================================================
   // Pin drivers
   // Value: latch AND serial, OR other alternates
   // Open drain drives only low; input or analog pins float
   // Open drain releases the pin for a one, so the level then rests
   // on the outside pull-up; the latch is never seen there
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         pinOut[i]    = (dataR[i] & serialOut[i]) | otherOut[i];
         pinOe[i]     = ~dirR[i] & ~effAna[i] &
                        ~(otypeR[i] & pinOut[i]);
         pinAnalog[i] = effAna[i];
      end
   end

   // Oscillator pin modes from the two-bit field
   // Codes 00 and 10 leave both oscillator pins as port inputs
   assign oscPinMode  = {oscR[OSC_EXT_BIT], oscR[OSC_SEL_BIT]};
   assign oscResonEn  = (oscPinMode == OSC_RESON);
   assign oscExtClkEn = (oscPinMode == OSC_EXTCLK);

   // ==========================================================
   // Checks
   // Bit operation request taken while the sequencer is idle
   sequence s_bop_req;
      regWr && regAddr == ADDR_BITSET && !busy;
   endsequence
   // Read phase, write-back phase, then idle again
   sequence s_bop_run;
      busy ##1 busy ##1 !busy;
   endsequence
   // No input pin is ever driven, on any bit
   a_input_hiz: assert property (@(posedge clk) disable iff (!rst_n)
      (pinOe & dirR) == '0) else $error("input pin driven");
   // All pins inputs: a data read returns the sampled pin levels
   a_read_pin: assert property (@(posedge clk) disable iff (!rst_n)
      (regRd && regAddr == ADDR_DATA && dirR == 8'hff) |=>
      regRdata == $past(pinIn[7:0])) else $error("bad read");
   // A bit operation keeps the sequencer busy for two cycles
   a_rmw_seq: assert property (@(posedge clk) disable iff (!rst_n)
      s_bop_req |=> s_bop_run) else $error("rmw length");
   // The read phase takes the whole byte, pins for inputs
   a_rmw_load: assert property (@(posedge clk) disable iff (!rst_n)
      (stR == BopRead) |=> bufR == $past(dataView))
      else $error("rmw source");
   // Write-back changes no bit but the targeted one
   a_rmw_keep: assert property (@(posedge clk) disable iff (!rst_n)
      (stR == BopWrite) |=> ((dataR ^ $past(bufR)) &
      ~(8'h01 << $past(bopR[BOP_IDX_LSB +: 3]))) == 8'h00)
      else $error("rmw other bits");
   // Any other alternate output high forces the pin value high
   a_or_mix: assert property (@(posedge clk) disable iff (!rst_n)
      (otherOut & ~pinOut) == '0) else $error("mix");
   // Pin value is low unless latch and serial, or another, are high
   a_and_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (pinOut & ~otherOut & ~(dataR & serialOut)) == '0)
      else $error("gate");
   // Resonator and external clock modes never both at once
   a_osc_mode: assert property (@(posedge clk) disable iff (!rst_n)
      !(oscResonEn && oscExtClkEn)) else $error("osc");
   // An open-drain pin never drives a high value
   a_od_high: assert property (@(posedge clk) disable iff (!rst_n)
      (otypeR & pinOut & pinOe) == '0) else $error("od");
   // First edge after reset: no pin driven yet
   a_reset_in: assert property (@(posedge clk)
      $rose(rst_n) |-> pinOe == '0) else $error("reset oe");
   // Small package: forced pins analog and never driven
   a_small_ana: assert property (@(posedge clk) disable iff (!rst_n)
      SMALL_PKG |-> ((pinAnalog & ANALOG_ONLY) == ANALOG_ONLY &&
      (pinOe & ANALOG_ONLY) == '0)) else $error("pkg analog");
endmodule

// ### test/ppfs_pin_model.sv
// External devices on the port pins of one port.
// Assumes the bench picks the level of every pin the device releases.
`timescale 1ns/1ps
module ppfs_pin_model #(
   parameter int WIDTH = 8
) (
   // Device side of the pins
   input  wire logic [WIDTH-1:0] pinOut,
   input  wire logic [WIDTH-1:0] pinOe,
   // Level of the outside sources
   input  wire logic [WIDTH-1:0] extLevel,
   // Level seen back by the device
   output logic      [WIDTH-1:0] pinIn
);
   // ==========================================================
   // Wire resolution
   // A released pin follows the outside source, never the latch
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ### test/tb_ppfs_port.sv
// Self-checking bench for the port pin function select block.
// Assumes the block answers reads one cycle later and never stalls.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
   fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_ppfs_port;
   import ppfs_pkg::*;
   // Direction, output type, latch, serial, other, expected out and drive enable
   typedef struct {logic [7:0] d, o, l, s, t, eo, ee;} ppfs_row_t;
   logic       clk = 0, rst_n = 0, regWr = 0, regRd = 0, busy;
   logic [3:0] regAddr = 0;
   logic [7:0] regWdata = 0, regRdata, serialOut = 8'hff, otherOut = 0;
   logic [7:0] pinIn, pinOut, pinOe, pinAnalog, extLvl = 8'ha5, rd;
   logic [1:0] oscPinMode;
   logic       oscResonEn, oscExtClkEn;
   int         fail_count = 0, checked = 0, cyc = 0, i;
   ppfs_row_t  rows [5] = '{
      '{8'h00, 8'h00, 8'h5a, 8'hff, 8'h00, 8'h5a, 8'hcf},
      '{8'h00, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h0f, 8'hcf},
      '{8'h00, 8'h00, 8'h00, 8'hff, 8'hc3, 8'hc3, 8'hcf},
      '{8'h0f, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hc0},
      '{8'h00, 8'hff, 8'h0f, 8'hff, 8'h00, 8'h0f, 8'hc0}};
   always #5 clk = ~clk;
   // ==========================================================
   // Design and the devices on its pins; pins 4 and 5 analog only
   ppfs_port #(.ANALOG_ONLY(8'h30), .SMALL_PKG(1'b1)) ppfs_port_inst (
      .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .serialOut(serialOut), .otherOut(otherOut), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .pinAnalog(pinAnalog),
      .oscPinMode(oscPinMode), .oscResonEn(oscResonEn),
      .oscExtClkEn(oscExtClkEn), .busy(busy));
   ppfs_pin_model ppfs_pin_model_inst (.pinOut(pinOut), .pinOe(pinOe),
      .extLevel(extLvl), .pinIn(pinIn));
   // ==========================================================
   // Bus tasks: strobes last one cycle, driven after the edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1; regAddr <= a; regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cut a hang short well past the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         fail_count++;
         stop_test();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1 `CHK("oe", 8'h00, pinOe)
      `CHK("analog", 8'h30, pinAnalog)
      rdr(ADDR_DIR); `CHK("dir", RST_DIR, rd)
      rdr(ADDR_DATA); `CHK("din", 8'h85, rd & 8'hcf)
      foreach (rows[k]) begin
         wr(ADDR_DIR, rows[k].d); wr(ADDR_OTYPE, rows[k].o);
         wr(ADDR_DATA, rows[k].l);
         serialOut <= rows[k].s; otherOut <= rows[k].t;
         rdr(ADDR_DATA);
         `CHK("rd", ((rows[k].d & extLvl) | (~rows[k].d & rows[k].l))
            & 8'hcf, rd & 8'hcf)
         `CHK("out", rows[k].eo & rows[k].ee, pinOut & rows[k].ee)
         `CHK("oe", rows[k].ee, pinOe)
      end
      serialOut <= 8'hff; otherOut <= 8'h00;
      wr(ADDR_OTYPE, 8'h00);
      wr(ADDR_ANALOG, 8'h01); `CHK("an", 8'h31, pinAnalog)
      `CHK("oe", 8'hce, pinOe)
      wr(ADDR_ANALOG, 8'h00);
      for (i = 0; i < 4; i++) begin
         wr(ADDR_OSC, {i[1:0], 6'h00});
         `CHK("mode", i[1:0], oscPinMode)
         `CHK("res", i == 1, oscResonEn)
         `CHK("ext", i == 3, oscExtClkEn)
      end
      // Set bit 0 while the other pins are inputs seen high
      extLvl = 8'hff; wr(ADDR_DIR, 8'hfe); wr(ADDR_DATA, 8'h00);
      wr(ADDR_BITSET, 8'h18); `CHK("busy", 1'b1, busy)
      for (i = 0; i < 10 && busy !== 1'b0; i++) begin
         @(posedge clk) #1;
      end
      #1 `CHK("busy", 1'b0, busy)
      wr(ADDR_BITSET, 8'h01);
      wr(ADDR_DATA, 8'h55); // refused while busy
      for (i = 0; i < 10 && busy !== 1'b0; i++) begin
         @(posedge clk) #1;
      end
      wr(ADDR_DIR, 8'h00); rdr(ADDR_DATA);
      `CHK("rmw", 8'hcd, rd & 8'hcf)
      `CHK("out", 8'hcd, pinOut & 8'hcf)
      wr(ADDR_DATA, 8'h01); `CHK("rw", 8'h01, pinOut & 8'hcf)
      rdr(4'hf); `CHK("unmap", 8'h00, rd)
      // Reset in mid-run with pins driven: all return to input
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK("rst oe", 8'h00, pinOe)
      @(posedge clk) rst_n <= 1'b1;
      rdr(ADDR_DIR); `CHK("rst dir", RST_DIR, rd)
      stop_test();
   end
endmodule
